// ==== design/bppu_pkg.sv ====
// shared constants and register map of the upper port pin block
package bppu_pkg;
  // bus geometry
  localparam int AXI_AW = 6;
  localparam int PORT_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [23:0] RDATA_PAD = 24'h00_0000;
  // register byte addresses
  localparam logic [5:0] REG_PIN = 6'h00;
  localparam logic [5:0] REG_LAT = 6'h04;
  localparam logic [5:0] REG_DIR = 6'h08;
  localparam logic [5:0] REG_ICM = 6'h0C;
  localparam logic [5:0] REG_IC2 = 6'h10;
  localparam logic [5:0] REG_IC3 = 6'h14;
  localparam logic [5:0] REG_ADC = 6'h18;
  localparam logic [5:0] REG_STAT = 6'h1C;
  localparam logic [5:0] REG_MASK = 6'h20;
  localparam logic [5:0] REG_CFG = 6'h24;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  // implemented bits and reset values
  localparam logic [7:0] IC2_MASK = 8'hF5;
  localparam logic [7:0] IC3_MASK = 8'hDB;
  localparam logic [7:0] ADC_MASK = 8'h3F;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] ICM_RST = 8'h00;
  localparam logic [7:0] IC2_RST = IC2_MASK;
  localparam logic [7:0] IC3_RST = 8'hC0;
  localparam logic [7:0] ADC_RST_ANA = 8'h00;
  localparam logic [7:0] ADC_RST_DIG = 8'h0F;
  // field positions
  localparam int ICM_FLAG = 0;
  localparam int IC2_PU_DIS = 7;
  localparam int STAT_CHG = 0;
  localparam int CFG_LVP = 0;
  localparam int CFG_ALT = 1;
  localparam int CFG_POR_ANA = 2;
  localparam int CFG_PROG = 3;
  // analog selection: pcfg codes below the limit make the low pins analog
  localparam logic [3:0] PCFG_DIG_LIMIT = 4'h4;
  localparam logic [7:0] ANA_PINS = 8'h1F;
  // pin roles
  localparam int CCP_PIN = 3;
  localparam int LVP_PIN = 5;
  localparam int PGC_PIN = 6;
  localparam int PGD_PIN = 7;
  localparam int CHG_LO = 4;
  localparam logic [7:0] LVP_PINS = 8'h20;
  localparam logic [7:0] PROG_PINS = 8'hC0;
endpackage : bppu_pkg

// ==== design/bppu_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module bppu_sync
  import bppu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pins and filtered levels
  input wire logic [PORT_W-1:0] pin_raw,
  output logic [PORT_W-1:0] pin_q
);
  typedef struct packed {
    logic [PORT_W-1:0] s1;
    logic [PORT_W-1:0] s2;
    logic [PORT_W-1:0] s3;
    logic [PORT_W-1:0] q;
  } bppu_sync_st_t;
  bppu_sync_st_t st;
  bppu_sync_st_t n;
  logic [PORT_W-1:0] agree;
  // s1 feeds only s2; a level counts once s2 and s3 agree, so one stray sample is dropped
  assign agree = ~(st.s2 ^ st.s3);
  always_comb begin
    n.s1 = pin_raw;
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.q = (agree & st.s3) | (~agree & st.q);
    if (!aresetn) begin
      n = '0;
    end
  end
  // state register
  always_ff @(posedge aclk) begin
    st <= n;
  end
  assign pin_q = st.q;
endmodule : bppu_sync

// ==== design/bppu_axil.sv ====
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/10ps
module bppu_axil
  import bppu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register strobes
  output logic wr_en,
  output logic [AXI_AW-1:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [AXI_AW-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok
);
  typedef struct packed {
    logic aw_hold;
    logic [AXI_AW-1:0] addr;
    logic w_hold;
    logic [7:0] data;
    logic lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } bppu_axil_st_t;
  bppu_axil_st_t st;
  bppu_axil_st_t n;
  logic go;
  // a write fires once both halves are parked; no new write until its response is taken
  assign go = st.aw_hold && st.w_hold && !st.bvalid;
  assign wr_en = go && st.lane0;
  assign wr_addr = st.addr;
  assign wr_data = st.data;
  assign rd_en = s_axi_arvalid && st.arready;
  assign rd_addr = s_axi_araddr;
  // channel bookkeeping
  always_comb begin
    n = st;
    if (s_axi_awvalid && st.awready) begin
      n.aw_hold = 1'b1;
      n.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      n.w_hold = 1'b1;
      n.data = s_axi_wdata[7:0];
      n.lane0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (go) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    n.awready = !n.aw_hold && !n.bvalid;
    n.wready = !n.w_hold && !n.bvalid;
    if (st.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_en) begin
      n.rvalid = 1'b1;
      n.rdata = rd_ok ? rd_data : LAT_RST;
      n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.rvalid;
    if (!aresetn) begin
      n = '0;
    end
  end
  // state register
  always_ff @(posedge aclk) begin
    st <= n;
  end
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = {RDATA_PAD, st.rdata};
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;
endmodule : bppu_axil

// ==== design/bppu_top.sv ====
// upper port pin block: registers, pin muxing, pull-ups, change interrupt
`timescale 1ns/10ps
module bppu_top
  import bppu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration straps, caught during reset
  input wire logic cfg_lvp,
  input wire logic cfg_ccp_alt,
  input wire logic cfg_por_analog,
  // programming and capture unit side
  input wire logic prog_dbg_en,
  input wire logic prog_data_out,
  input wire logic prog_data_oe,
  input wire logic ccp_cmp_out,
  output logic ccp_capture,
  output logic prog_clk,
  output logic prog_data_in,
  output logic lvp_entry,
  // port pins
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe_n,
  output logic [PORT_W-1:0] pullup_en,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [7:0] lat;
    logic [7:0] dir;
    logic [7:0] icm;
    logic [7:0] ic2;
    logic [7:0] ic3;
    logic [7:0] adc;
    logic [3:0] old;
    logic stat;
    logic mask;
    logic cfg_lvp;
    logic cfg_alt;
    logic cfg_por;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic [7:0] pullup_en;
    logic ccp_cap;
    logic prog_clk;
    logic prog_din;
    logic lvp_entry;
    logic irq;
  } bppu_top_st_t;
  bppu_top_st_t st;
  bppu_top_st_t n;

  logic wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_ok;
  logic rd_en;
  logic [AXI_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_ok;
  logic [PORT_W-1:0] pin_q;
  logic analog;
  logic ccp_here;
  logic [7:0] ovr;
  logic [7:0] blank;
  logic [3:0] chg_src;
  logic mism;
  logic pin_snap;

  // bus slave
  bppu_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  bppu_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(pin_in),
    .pin_q(pin_q)
  );

  // pin ownership; a programming function owns its pins whatever the direction bits say
  assign analog = st.adc[3:0] < PCFG_DIG_LIMIT;
  assign ccp_here = !st.cfg_alt;
  assign ovr = (st.cfg_lvp ? LVP_PINS : LAT_RST) | (prog_dbg_en ? PROG_PINS : LAT_RST);
  assign blank = ovr | (analog ? ANA_PINS : LAT_RST);
  assign chg_src = st.dir[PORT_W-1:CHG_LO] & ~ovr[PORT_W-1:CHG_LO];
  assign mism = |((pin_q[PORT_W-1:CHG_LO] ^ st.old) & chg_src);
  // any read of the pin register, or a write with byte lane 0 set, re-arms the comparison
  assign pin_snap = (rd_en && rd_addr == REG_PIN) || (wr_en && wr_addr == REG_PIN);
  assign wr_ok = (wr_addr[1:0] == WORD_ALIGN) && (wr_addr <= REG_CFG);

  // register read decode
  always_comb begin
    rd_data = LAT_RST;
    rd_ok = (rd_addr[1:0] == WORD_ALIGN) && (rd_addr <= REG_CFG);
    case (rd_addr)
      REG_PIN: rd_data = pin_q & ~blank;
      REG_LAT: rd_data = st.lat;
      REG_DIR: rd_data = st.dir;
      REG_ICM: rd_data = st.icm;
      REG_IC2: rd_data = st.ic2 & IC2_MASK;
      REG_IC3: rd_data = st.ic3 & IC3_MASK;
      REG_ADC: rd_data = st.adc & ADC_MASK;
      REG_STAT: rd_data[STAT_CHG] = st.stat;
      REG_MASK: rd_data[STAT_CHG] = st.mask;
      REG_CFG: begin
        rd_data[CFG_LVP] = st.cfg_lvp;
        rd_data[CFG_ALT] = st.cfg_alt;
        rd_data[CFG_POR_ANA] = st.cfg_por;
        rd_data[CFG_PROG] = prog_dbg_en;
      end
      default: rd_data = LAT_RST;
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    n = st;
    // software writes use byte lane 0 only
    if (wr_en) begin
      case (wr_addr)
        REG_PIN, REG_LAT: n.lat = wr_data;
        REG_DIR: n.dir = wr_data;
        REG_ICM: n.icm = wr_data;
        REG_IC2: n.ic2 = wr_data & IC2_MASK;
        REG_IC3: n.ic3 = wr_data & IC3_MASK;
        REG_ADC: n.adc = wr_data & ADC_MASK;
        REG_STAT: begin
          if (wr_data[STAT_CHG]) begin
            n.stat = 1'b0;
          end
        end
        REG_MASK: n.mask = wr_data[STAT_CHG];
        default: n.lat = st.lat;
      endcase
    end
    if (pin_snap) begin
      n.old = pin_q[PORT_W-1:CHG_LO];
    end
    if (mism) begin
      n.icm[ICM_FLAG] = 1'b1;
      n.stat = 1'b1;
    end
    for (int i = 0; i < PORT_W; i++) begin
      n.pin_out[i] = st.lat[i];
      n.pin_oe_n[i] = st.dir[i];
    end
    if (ccp_here && !st.dir[CCP_PIN]) begin
      n.pin_out[CCP_PIN] = ccp_cmp_out;
    end
    n.ccp_cap = ccp_here && st.dir[CCP_PIN] && pin_q[CCP_PIN];
    if (st.cfg_lvp) begin
      n.pin_oe_n[LVP_PIN] = 1'b1;
    end
    n.lvp_entry = st.cfg_lvp && pin_q[LVP_PIN];
    if (prog_dbg_en) begin
      n.pin_oe_n[PGC_PIN] = 1'b1;
      n.pin_oe_n[PGD_PIN] = !prog_data_oe;
      n.pin_out[PGD_PIN] = prog_data_out;
    end
    n.prog_clk = prog_dbg_en && pin_q[PGC_PIN];
    n.prog_din = prog_dbg_en && pin_q[PGD_PIN];
    n.pullup_en = st.dir & ~blank & {PORT_W{!st.ic2[IC2_PU_DIS]}};
    // level interrupt from the sticky bit
    n.irq = st.stat && st.mask;
    if (!aresetn) begin
      n = '0;
      n.lat = LAT_RST;
      n.dir = DIR_RST;
      n.icm = ICM_RST;
      n.ic2 = IC2_RST;
      n.ic3 = IC3_RST;
      n.adc = cfg_por_analog ? ADC_RST_ANA : ADC_RST_DIG;
      n.cfg_lvp = cfg_lvp;
      n.cfg_alt = cfg_ccp_alt;
      n.cfg_por = cfg_por_analog;
      n.pin_oe_n = DIR_RST;
    end
  end

  // state register; synchronous reset is applied in the next-state logic
  always_ff @(posedge aclk) begin
    st <= n;
  end

  // outputs straight from the state register
  assign pin_out = st.pin_out;
  assign pin_oe_n = st.pin_oe_n;
  assign pullup_en = st.pullup_en;
  assign ccp_capture = st.ccp_cap;
  assign prog_clk = st.prog_clk;
  assign prog_data_in = st.prog_din;
  assign lvp_entry = st.lvp_entry;
  assign irq = st.irq;

  // checks on the registered behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_pin4_drive: assert property (
    !st.dir[4] |=> !st.pin_oe_n[4] && st.pin_out[4] == $past(st.lat[4]))
    else $error("pin four not driven from latch");

  a_pullup_gate: assert property (
    st.pullup_en[4] |-> $past(st.dir[4]) && !$past(st.ic2[IC2_PU_DIS]) && !$past(analog))
    else $error("pull-up on while not allowed");

  a_change_src: assert property (
    $rose(st.stat) |-> $past(mism) && $past(chg_src != 4'h0))
    else $error("change flag rose without input mismatch");

  a_lvp_owns: assert property (
    st.cfg_lvp |=> st.pin_oe_n[LVP_PIN] && !st.pullup_en[LVP_PIN])
    else $error("low-voltage pin still used as port");

  a_prog_clock: assert property (
    prog_dbg_en |=> st.pin_oe_n[PGC_PIN] && st.pullup_en[PGD_PIN:PGC_PIN] == 2'h0)
    else $error("programming pins still used as port");

  a_prog_data: assert property (
    prog_dbg_en && prog_data_oe |=> !st.pin_oe_n[PGD_PIN] && st.pin_out[PGD_PIN] == $past(prog_data_out))
    else $error("programming data not driven");

  a_ccp_route: assert property (
    st.cfg_alt && !st.dir[CCP_PIN] |=> st.pin_out[CCP_PIN] == $past(st.lat[CCP_PIN]))
    else $error("capture unit reached pin while routed away");

  a_ccp_drive: assert property (
    !st.cfg_alt && !st.dir[CCP_PIN] |=> st.pin_out[CCP_PIN] == $past(ccp_cmp_out) && !st.ccp_cap)
    else $error("compare output not on pin");

  a_por_analog: assert property (
    $rose(aresetn) |-> st.adc == ($past(cfg_por_analog) ? ADC_RST_ANA : ADC_RST_DIG))
    else $error("analog selection wrong after reset");

  a_latch_read: assert property (
    rd_en && rd_addr == REG_LAT && !wr_en |=> s_axi_rdata[7:0] == $past(st.lat) && s_axi_rvalid)
    else $error("latch read did not return latch");

  a_hole_zero: assert property (
    rd_en && rd_addr == REG_IC3 |=> (s_axi_rdata[7:0] & ~IC3_MASK) == 8'h00)
    else $error("unimplemented bits read non-zero");

  a_flag_hold: assert property (
    mism |=> st.stat && st.icm[ICM_FLAG] ##1 st.irq == $past(st.mask))
    else $error("mismatch did not set flag");

  a_reset_pull: assert property (
    $rose(aresetn) |-> st.ic2[IC2_PU_DIS] ##1 st.pullup_en == 8'h00)
    else $error("pull-ups on after reset");

  a_float_in: assert property (
    st.dir[2] |=> st.pin_oe_n[2])
    else $error("input pin still driven");

  c_change_irq: cover property (mism ##1 st.irq);
  c_prog_mode: cover property (prog_dbg_en && prog_data_oe ##1 !st.pin_oe_n[PGD_PIN]);
  c_ccp_out: cover property (!st.cfg_alt && !st.dir[CCP_PIN] ##1 st.pin_out[CCP_PIN]);
  c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule : bppu_top

// ==== verif/bppu_pin_model.sv ====
// pad and far-side model: keypad switches, programmer, pull-ups and floating lines
`timescale 1ns/10ps
module bppu_pin_model
  import bppu_pkg::*;
(
  // clock
  input wire logic aclk,
  // device side of the pads
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe_n,
  input wire logic [PORT_W-1:0] pullup_en,
  // outside drivers, switches or programmer
  input wire logic [PORT_W-1:0] ext_val,
  input wire logic [PORT_W-1:0] ext_en,
  // resolved pad levels
  output logic [PORT_W-1:0] pin_in
);
  logic [PORT_W-1:0] float_reg = 8'h00;

  // an undriven pad wanders each cycle so a stale level never looks valid
  always @(posedge aclk) begin
    float_reg <= ~pin_in;
  end

  // outside drives only when the device lets go
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_reg[i];
    end
  end
endmodule : bppu_pin_model

// ==== verif/bppu_top_tb.sv ====
// self-checking bench for the upper port pin block
`timescale 1ns/10ps
module bppu_top_tb
  import bppu_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic cfg_lvp = 1'b0, cfg_ccp_alt = 1'b0, cfg_por_analog = 1'b1;
  logic prog_dbg_en = 1'b0, prog_data_out = 1'b0, prog_data_oe = 1'b0, ccp_cmp_out = 1'b0;
  logic [7:0] ext_val = 8'hA5, ext_en = 8'hFF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic ccp_capture, prog_clk, prog_data_in, lvp_entry, irq;
  logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en, v;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int num_errors = 0, check_count = 0;
  logic [5:0] ra [9] = '{REG_LAT, REG_DIR, REG_ICM, REG_IC2, REG_IC3, REG_ADC, REG_STAT, REG_MASK, REG_CFG};
  // the snapshot clears at reset and the pins leave zero, so the change flag is up by these reads
  logic [7:0] rv [9] = '{8'h00, 8'hFF, 8'h01, 8'hF5, 8'hC0, 8'h00, 8'h01, 8'h00, 8'h04};
  logic [5:0] ma [3] = '{REG_IC2, REG_IC3, REG_ADC};
  logic [7:0] mv [3] = '{8'hF5, 8'hDB, 8'h3F};

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  bppu_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_lvp, .cfg_ccp_alt,
    .cfg_por_analog, .prog_dbg_en, .prog_data_out, .prog_data_oe, .ccp_cmp_out, .ccp_capture, .prog_clk,
    .prog_data_in, .lvp_entry, .pin_in, .pin_out, .pin_oe_n, .pullup_en, .irq);

  bppu_pin_model u_pins (.aclk, .pin_out, .pin_oe_n, .pullup_en, .ext_val, .ext_en, .pin_in);

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // a wait that used its whole bound ends the run
  task automatic timed_out(input int n);
    if (n >= 100) begin
      num_errors++;
      $display("CHECK FAILED wait expected answer seen none");
      final_report();
    end
  endtask : timed_out

  task automatic do_reset(input logic low_voltage_prog_cfg, input logic alt, input logic ana);
    cfg_lvp <= low_voltage_prog_cfg;
    cfg_ccp_alt <= alt;
    cfg_por_analog <= ana;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // address and data go out together; each drops at its own handshake
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {RDATA_PAD, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (n < 100 && s_axi_bvalid !== 1'b1);
    timed_out(n);
    check("bresp", {6'h00, s_axi_bresp}, {6'h00, er});
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    exp_q.push_back({er, RDATA_PAD, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (n < 100 && s_axi_rvalid !== 1'b1);
    timed_out(n);
  endtask : rd

  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask : settle

  task automatic wait_irq(input logic lv);
    int n;
    n = 0;
    while (n < 100 && irq !== lv) begin
      @(posedge aclk);
      n++;
    end
    timed_out(n);
  endtask : wait_irq

  // scoreboard: each read answer against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("rdata", s_axi_rdata[7:0], e[7:0]);
      check("rresp pad", {s_axi_rresp, 5'h00, |s_axi_rdata[31:8]}, {e[33:32], 6'h00});
    end
  end

  initial begin
    void'($urandom(32));
    do_reset(1'b0, 1'b0, 1'b1);
    check("oe_n", pin_oe_n, 8'hFF);
    check("pullup", pullup_en, 8'h00);
    foreach (ra[i]) rd(ra[i], rv[i], RESP_OKAY);
    rd(REG_PIN, 8'hA0, RESP_OKAY);
    $display("test reset done");
    foreach (ma[i]) begin
      wr(ma[i], 8'hFF, RESP_OKAY);
      rd(ma[i], mv[i], RESP_OKAY);
    end
    wr(6'h28, 8'h01, RESP_SLVERR);
    rd(6'h28, 8'h00, RESP_SLVERR);
    rd(6'h06, 8'h00, RESP_SLVERR);
    wr(REG_CFG, 8'hFF, RESP_OKAY);
    rd(REG_CFG, 8'h04, RESP_OKAY);
    // a write without byte lane 0 must leave the latch alone
    s_axi_wstrb <= 4'hE;
    wr(REG_LAT, 8'h5A, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(REG_LAT, 8'h00, RESP_OKAY);
    wr(REG_IC2, 8'h75, RESP_OKAY);
    settle();
    check("pullup", pullup_en, 8'hFF);
    wr(REG_ADC, 8'h00, RESP_OKAY);
    settle();
    check("pullup analog", pullup_en, 8'hE0);
    $display("test registers done");
    v = 8'($urandom());
    wr(REG_LAT, v, RESP_OKAY);
    wr(REG_DIR, 8'h00, RESP_OKAY);
    settle();
    check("pin_out", pin_out, {v[7:4], 1'b0, v[2:0]});
    check("oe_n", pin_oe_n, 8'h00);
    check("pullup out", pullup_en, 8'h00);
    rd(REG_LAT, v, RESP_OKAY);
    ccp_cmp_out <= 1'b1;
    settle();
    check("ccp out", pin_out, {v[7:4], 1'b1, v[2:0]});
    $display("test outputs done");
    wr(REG_ADC, 8'h0F, RESP_OKAY);
    wr(REG_DIR, 8'hFF, RESP_OKAY);
    ext_val <= 8'($urandom());
    settle();
    check("capture", {7'h00, ccp_capture}, {7'h00, ext_val[3]});
    rd(REG_PIN, ext_val, RESP_OKAY);
    $display("test inputs done");
    wr(REG_MASK, 8'h01, RESP_OKAY);
    wr(REG_STAT, 8'h01, RESP_OKAY);
    wr(REG_ICM, 8'h00, RESP_OKAY);
    check("irq idle", {7'h00, irq}, 8'h00);
    ext_val[4] <= ~ext_val[4];
    wait_irq(1'b1);
    rd(REG_STAT, 8'h01, RESP_OKAY);
    rd(REG_ICM, 8'h01, RESP_OKAY);
    wr(REG_STAT, 8'h01, RESP_OKAY);
    rd(REG_STAT, 8'h01, RESP_OKAY);
    rd(REG_PIN, ext_val, RESP_OKAY);
    wr(REG_STAT, 8'h01, RESP_OKAY);
    wait_irq(1'b0);
    rd(REG_STAT, 8'h00, RESP_OKAY);
    wr(REG_LAT, ~ext_val, RESP_OKAY);
    wr(REG_DIR, 8'h0F, RESP_OKAY);
    settle();
    rd(REG_STAT, 8'h00, RESP_OKAY);
    wr(REG_MASK, 8'h00, RESP_OKAY);
    wr(REG_DIR, 8'hFF, RESP_OKAY);
    ext_val[7] <= ~ext_val[7];
    settle();
    check("irq masked", {7'h00, irq}, 8'h00);
    rd(REG_STAT, 8'h01, RESP_OKAY);
    $display("test change done");
    wr(REG_DIR, 8'h00, RESP_OKAY);
    prog_dbg_en <= 1'b1;
    prog_data_oe <= 1'b1;
    prog_data_out <= 1'b1;
    ext_val[6] <= 1'b1;
    settle();
    check("prog oe_n", pin_oe_n, 8'h40);
    check("prog out", {7'h00, pin_out[7]}, 8'h01);
    check("prog clk", {7'h00, prog_clk}, 8'h01);
    check("prog echo", {7'h00, prog_data_in}, 8'h01);
    prog_data_oe <= 1'b0;
    ext_val[7] <= 1'b0;
    settle();
    check("prog in", {pin_oe_n[7], 6'h00, prog_data_in}, 8'h80);
    rd(REG_CFG, 8'h0C, RESP_OKAY);
    prog_dbg_en <= 1'b0;
    settle();
    check("prog clk off", {7'h00, prog_clk}, 8'h00);
    $display("test programming done");
    do_reset(1'b1, 1'b1, 1'b0);
    rd(REG_ADC, 8'h0F, RESP_OKAY);
    rd(REG_CFG, 8'h03, RESP_OKAY);
    ccp_cmp_out <= 1'b0;
    ext_val[5] <= 1'b1;
    ext_val[3] <= 1'b1;
    wr(REG_LAT, 8'hFF, RESP_OKAY);
    wr(REG_DIR, 8'h00, RESP_OKAY);
    settle();
    check("lvp oe_n", pin_oe_n, 8'h20);
    check("lvp entry", {7'h00, lvp_entry}, 8'h01);
    check("alt pin3", {7'h00, pin_out[3]}, 8'h01);
    wr(REG_DIR, 8'hFF, RESP_OKAY);
    settle();
    check("alt capture", {7'h00, ccp_capture}, 8'h00);
    $display("test straps done");
    settle();
    check("reads left", 8'(exp_q.size()), 8'h00);
    final_report();
  end
endmodule : bppu_top_tb
